/* logic/cfc_flow_ctrl.v */
// pipeline control for conditional branch, call, exit and execute_if
// assumes the decode stage pulses instr_go for each conditional
// instruction and slot_go for each instruction decoded after it;
// flags and sum come from logic on ref_clk, the branch pin from outside
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "cfc_consts.vh"

module cfc_flow_ctrl #(
    parameter SUM_W = 32,
    parameter PC_W = 16,
    parameter CNT_W = 16
) (
    input wire ref_clk,
    input wire rst,
    // decode side
    input wire instr_go,
    input wire [2:0] instr_kind,
    input wire [`CFC_COND_W-1:0] instr_cond,
    input wire [PC_W-1:0] instr_target,
    input wire [PC_W-1:0] instr_next_pc,
    input wire slot_go,
    input wire slot_two_word,
    // status
    input wire [SUM_W-1:0] sum_value,
    input wire carry_flag,
    input wire wrap_flag,
    input wire test_flag,
    input wire branch_pin,
    // pipeline controls
    output reg stall_dec_q,
    output reg flush_q,
    output reg pc_load_q,
    output reg [PC_W-1:0] pc_target_q,
    output reg ret_push_q,
    output reg [PC_W-1:0] ret_addr_q,
    output reg ret_pop_q,
    output reg nop_sub_q,
    output reg cond_met_q,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q
);
    // ==========================================================
    // states
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_FLUSH = 3'h2;
    localparam ST_DSLOT = 3'h3;
    localparam ST_XSLOT = 3'h4;

    // words a decoded slot instruction occupies
    function [1:0] words_of;
        input two_word;
        begin
            words_of = two_word ? 2'h2 : 2'h1;
        end
    endfunction

    // true when a slot instruction uses up the remaining words
    function slots_done;
        input two_word;
        input [1:0] left;
        begin
            slots_done = (words_of(two_word) >= left);
        end
    endfunction

    // ==========================================================
    // declarations
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg [1:0] left_q;
    reg [1:0] left_d;
    reg [2:0] kind_q;
    reg [2:0] kind_d;
    reg [`CFC_COND_W-1:0] cond_q;
    reg [`CFC_COND_W-1:0] cond_d;
    reg [PC_W-1:0] tgt_q;
    reg [PC_W-1:0] tgt_d;
    reg [PC_W-1:0] nxt_q;
    reg [PC_W-1:0] nxt_d;
    reg pin_s1_q;
    reg pin_s2_q;
    reg [SUM_W-1:0] sum_past_q;
    reg carry_past_q;
    reg wrap_past_q;
    reg test_past_q;
    reg pin_past_q;
    reg stall_d;
    reg flush_d;
    reg pc_load_d;
    reg ret_push_d;
    reg ret_pop_d;
    reg nop_sub_d;
    reg cond_met_d;
    reg ev_met;
    reg ev_skip;
    reg cnt_en_q;
    reg [CNT_W-1:0] taken_cnt_q;
    reg [CNT_W-1:0] skip_cnt_q;
    wire met_live;
    wire met_go;
    wire met_past;
    wire is_delayed;
    wire is_xc;
    wire ctrl_wr;
    wire cnt_clr;

    // ==========================================================
    // branch pin synchroniser; only the second stage is read
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= branch_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // status one cycle old for execute_if; an interrupt taken before
    // execute_if simply delays instr_go, so its flag changes are seen
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            sum_past_q <= {SUM_W{1'b0}};
            carry_past_q <= 1'b0;
            wrap_past_q <= 1'b0;
            test_past_q <= 1'b0;
            pin_past_q <= 1'b1;
        end
        else
        begin
            sum_past_q <= sum_value;
            carry_past_q <= carry_flag;
            wrap_past_q <= wrap_flag;
            test_past_q <= test_flag;
            pin_past_q <= pin_s2_q;
        end
    end

    // ==========================================================
    // evaluators: held instruction on live status, new instruction on
    // live status, new instruction on status one cycle old
    cfc_cond_eval #(.SUM_W(SUM_W)) u_eval_live (
        .cond(cond_q),
        .sum_value(sum_value),
        .carry_flag(carry_flag),
        .wrap_flag(wrap_flag),
        .test_flag(test_flag),
        .pin_level(pin_s2_q),
        .met(met_live)
    );

    cfc_cond_eval #(.SUM_W(SUM_W)) u_eval_go (
        .cond(instr_cond),
        .sum_value(sum_value),
        .carry_flag(carry_flag),
        .wrap_flag(wrap_flag),
        .test_flag(test_flag),
        .pin_level(pin_s2_q),
        .met(met_go)
    );

    cfc_cond_eval #(.SUM_W(SUM_W)) u_eval_past (
        .cond(instr_cond),
        .sum_value(sum_past_q),
        .carry_flag(carry_past_q),
        .wrap_flag(wrap_past_q),
        .test_flag(test_past_q),
        .pin_level(pin_past_q),
        .met(met_past)
    );

    // every conditional kind carries the full grouped condition field
    assign is_delayed = (instr_kind == `CFC_K_BRANCH_D) ||
                        (instr_kind == `CFC_K_CALL_D) ||
                        (instr_kind == `CFC_K_EXIT_D);
    assign is_xc = (instr_kind == `CFC_K_XC1) || (instr_kind == `CFC_K_XC2);

    // ==========================================================
    // control state machine
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        left_d = left_q;
        kind_d = kind_q;
        cond_d = cond_q;
        tgt_d = tgt_q;
        nxt_d = nxt_q;
        stall_d = 1'b0;
        flush_d = 1'b0;
        pc_load_d = 1'b0;
        ret_push_d = 1'b0;
        ret_pop_d = 1'b0;
        nop_sub_d = 1'b0;
        cond_met_d = cond_met_q;
        ev_met = 1'b0;
        ev_skip = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (instr_go)
                begin
                    kind_d = instr_kind;
                    cond_d = instr_cond;
                    tgt_d = instr_target;
                    nxt_d = instr_next_pc;
                    if (is_xc)
                    begin
                        // decision made before the covered words decode
                        cond_met_d = met_past;
                        ev_met = met_past;
                        ev_skip = !met_past;
                        if (!met_past)
                        begin
                            left_d = (instr_kind == `CFC_K_XC2) ? 2'h2 : 2'h1;
                            nop_sub_d = 1'b1;
                            state_d = ST_XSLOT;
                        end
                    end
                    else if (is_delayed)
                    begin
                        // status sampled now, before any slot instruction
                        cond_met_d = met_go;
                        ev_met = met_go;
                        ev_skip = !met_go;
                        if (met_go)
                        begin
                            left_d = `CFC_SLOT_WORDS;
                            state_d = ST_DSLOT;
                        end
                    end
                    else
                    begin
                        // previous instruction still completing its flags
                        stall_d = 1'b1;
                        cnt_d = `CFC_WAIT_CYC;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (cnt_q > 2'h1)
                begin
                    cnt_d = cnt_q - 2'h1;
                    stall_d = 1'b1;
                end
                else
                begin
                    cond_met_d = met_live;
                    ev_met = met_live;
                    ev_skip = !met_live;
                    if (met_live)
                    begin
                        // redirect and refill: two more dead cycles
                        pc_load_d = (kind_q != `CFC_K_EXIT);
                        ret_push_d = (kind_q == `CFC_K_CALL);
                        ret_pop_d = (kind_q == `CFC_K_EXIT);
                        flush_d = 1'b1;
                        stall_d = 1'b1;
                        cnt_d = `CFC_FLUSH_CYC;
                        state_d = ST_FLUSH;
                    end
                    else
                    begin
                        // fetched next instruction goes on to decode
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_FLUSH:
            begin
                if (cnt_q > 2'h1)
                begin
                    cnt_d = cnt_q - 2'h1;
                    stall_d = 1'b1;
                end
                else
                begin
                    state_d = ST_IDLE;
                end
            end
            ST_DSLOT:
            begin
                // slot words run normally; transfer after the last one
                if (slot_go)
                begin
                    if (slots_done(slot_two_word, left_q))
                    begin
                        pc_load_d = (kind_q != `CFC_K_EXIT_D);
                        ret_push_d = (kind_q == `CFC_K_CALL_D);
                        ret_pop_d = (kind_q == `CFC_K_EXIT_D);
                        left_d = 2'h0;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        left_d = left_q - words_of(slot_two_word);
                    end
                end
            end
            ST_XSLOT:
            begin
                nop_sub_d = 1'b1;
                if (slot_go)
                begin
                    if (slots_done(slot_two_word, left_q))
                    begin
                        nop_sub_d = 1'b0;
                        left_d = 2'h0;
                        state_d = ST_IDLE;
                    end
                    else
                    begin
                        left_d = left_q - words_of(slot_two_word);
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state and output registers
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 2'h0;
            left_q <= 2'h0;
            kind_q <= `CFC_K_BRANCH;
            cond_q <= {`CFC_COND_W{1'b0}};
            tgt_q <= {PC_W{1'b0}};
            nxt_q <= {PC_W{1'b0}};
            stall_dec_q <= 1'b0;
            flush_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_target_q <= {PC_W{1'b0}};
            ret_push_q <= 1'b0;
            ret_addr_q <= {PC_W{1'b0}};
            ret_pop_q <= 1'b0;
            nop_sub_q <= 1'b0;
            cond_met_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
            kind_q <= kind_d;
            cond_q <= cond_d;
            tgt_q <= tgt_d;
            nxt_q <= nxt_d;
            stall_dec_q <= stall_d;
            flush_q <= flush_d;
            pc_load_q <= pc_load_d;
            pc_target_q <= tgt_d;
            ret_push_q <= ret_push_d;
            ret_addr_q <= nxt_d;
            ret_pop_q <= ret_pop_d;
            nop_sub_q <= nop_sub_d;
            cond_met_q <= cond_met_d;
        end
    end

    // ==========================================================
    // statistics counters; an event in the clear cycle counts as one
    assign ctrl_wr = reg_wr && (reg_addr == `CFC_A_CTRL);
    assign cnt_clr = ctrl_wr && reg_wdata[`CFC_CTRL_CNT_CLR];

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_en_q <= `CFC_CTRL_RST;
            taken_cnt_q <= {CNT_W{1'b0}};
            skip_cnt_q <= {CNT_W{1'b0}};
        end
        else
        begin
            if (ctrl_wr)
            begin
                cnt_en_q <= reg_wdata[`CFC_CTRL_CNT_EN];
            end
            if (cnt_clr)
            begin
                taken_cnt_q <= {{(CNT_W-1){1'b0}}, ev_met && cnt_en_q};
                skip_cnt_q <= {{(CNT_W-1){1'b0}}, ev_skip && cnt_en_q};
            end
            else if (cnt_en_q)
            begin
                taken_cnt_q <= taken_cnt_q + {{(CNT_W-1){1'b0}}, ev_met};
                skip_cnt_q <= skip_cnt_q + {{(CNT_W-1){1'b0}}, ev_skip};
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            reg_rdata_q <= 32'h00000000;
        end
        else if (reg_rd)
        begin
            case (reg_addr)
                `CFC_A_CTRL: reg_rdata_q <= {31'h00000000, cnt_en_q};
                `CFC_A_STAT: reg_rdata_q <= {24'h000000, nop_sub_q, stall_dec_q,
                                             cond_met_q, 2'h0, state_q};
                `CFC_A_TAKEN: reg_rdata_q <= {{(32-CNT_W){1'b0}}, taken_cnt_q};
                `CFC_A_SKIP: reg_rdata_q <= {{(32-CNT_W){1'b0}}, skip_cnt_q};
                default: reg_rdata_q <= 32'h00000000;
            endcase
        end
        else
        begin
            reg_rdata_q <= 32'h00000000;
        end
    end

endmodule // cfc_flow_ctrl

/* logic/cfc_consts.vh */
// constants for the conditional flow control block
// assumes a single 20 MHz core clock and a decode stage that reports
// each conditional instruction and each following instruction
`ifndef CFC_CONSTS_VH
`define CFC_CONSTS_VH

// ==========================================================
// timing
`define CFC_CLK_NS 50
`define CFC_TAKEN_CYC 4
`define CFC_UNTAKEN_CYC 2
`define CFC_WAIT_CYC 2'h1
`define CFC_FLUSH_CYC 2'h2
`define CFC_SLOT_WORDS 2'h2

// ==========================================================
// instruction kinds
`define CFC_K_BRANCH 3'h0
`define CFC_K_CALL 3'h1
`define CFC_K_EXIT 3'h2
`define CFC_K_BRANCH_D 3'h3
`define CFC_K_CALL_D 3'h4
`define CFC_K_EXIT_D 3'h5
`define CFC_K_XC1 3'h6
`define CFC_K_XC2 3'h7

// ==========================================================
// condition field: [10] g1 en, [9:7] g1 sel, [6] g2 en, [5] g2 set,
// [4] g3 en, [3] g3 set, [2] g4 en, [1:0] g4 sel
`define CFC_COND_W 11
`define CFC_G1_EN 10
`define CFC_G1_HI 9
`define CFC_G1_LO 7
`define CFC_G2_EN 6
`define CFC_G2_SET 5
`define CFC_G3_EN 4
`define CFC_G3_SET 3
`define CFC_G4_EN 2
`define CFC_G4_HI 1
`define CFC_G4_LO 0
`define CFC_G1_ZERO 3'h0
`define CFC_G1_NONZERO 3'h1
`define CFC_G1_NEG 3'h2
`define CFC_G1_NONPOS 3'h3
`define CFC_G1_POS 3'h4
`define CFC_G1_NONNEG 3'h5
`define CFC_G4_TC_CLR 2'h0
`define CFC_G4_TC_SET 2'h1
`define CFC_G4_PIN_LOW 2'h2

// ==========================================================
// register map
`define CFC_A_CTRL 4'h0
`define CFC_A_STAT 4'h4
`define CFC_A_TAKEN 4'h8
`define CFC_A_SKIP 4'hC
`define CFC_CTRL_CNT_EN 0
`define CFC_CTRL_CNT_CLR 1
`define CFC_CTRL_RST 1'h1

`endif

/* logic/cfc_cond_eval.v */
// condition evaluator for the conditional flow control block
// assumes flags and accumulator are stable in the cycle they are read
`timescale 1ns/100ps
`include "cfc_consts.vh"

module cfc_cond_eval #(
    parameter SUM_W = 32
) (
    input wire [`CFC_COND_W-1:0] cond,
    input wire [SUM_W-1:0] sum_value,
    input wire carry_flag,
    input wire wrap_flag,
    input wire test_flag,
    input wire pin_level,
    output wire met
);
    // ==========================================================
    // per-group tests
    wire s_zero;
    wire s_neg;
    reg g1_ok;
    wire g2_ok;
    wire g3_ok;
    reg g4_ok;

    assign s_zero = (sum_value == {SUM_W{1'b0}});
    assign s_neg = sum_value[SUM_W-1];

    // signed compare of the sum register against zero
    always @*
    begin
        case (cond[`CFC_G1_HI:`CFC_G1_LO])
            `CFC_G1_ZERO: g1_ok = s_zero;
            `CFC_G1_NONZERO: g1_ok = !s_zero;
            `CFC_G1_NEG: g1_ok = s_neg;
            `CFC_G1_NONPOS: g1_ok = s_neg || s_zero;
            `CFC_G1_POS: g1_ok = !s_neg && !s_zero;
            `CFC_G1_NONNEG: g1_ok = !s_neg;
            default: g1_ok = 1'b0; // undefined codes never satisfy
        endcase
    end

    assign g2_ok = (wrap_flag == cond[`CFC_G2_SET]);
    assign g3_ok = (carry_flag == cond[`CFC_G3_SET]);

    // test flag or branch pin, the pin being active low
    always @*
    begin
        case (cond[`CFC_G4_HI:`CFC_G4_LO])
            `CFC_G4_TC_CLR: g4_ok = !test_flag;
            `CFC_G4_TC_SET: g4_ok = test_flag;
            `CFC_G4_PIN_LOW: g4_ok = !pin_level;
            default: g4_ok = 1'b0;
        endcase
    end

    // ==========================================================
    // one field per group, disabled groups pass; all-off is always_true
    assign met = (!cond[`CFC_G1_EN] || g1_ok) &&
                 (!cond[`CFC_G2_EN] || g2_ok) &&
                 (!cond[`CFC_G3_EN] || g3_ok) &&
                 (!cond[`CFC_G4_EN] || g4_ok);

endmodule // cfc_cond_eval

/* tb/cfc_checker.sv */
// concurrent checks on the conditional flow control pipeline outputs
// assumes binding to cfc_flow_ctrl and a bench that keeps the request spacing
`timescale 1ns/100ps
`include "cfc_consts.vh"

module cfc_checker #(
    parameter SUM_W = 32,
    parameter PC_W = 16,
    parameter CNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic instr_go,
    input wire logic [2:0] instr_kind,
    input wire logic [`CFC_COND_W-1:0] instr_cond,
    input wire logic [PC_W-1:0] instr_target,
    input wire logic [PC_W-1:0] instr_next_pc,
    input wire logic slot_go,
    input wire logic slot_two_word,
    input wire logic stall_dec_q,
    input wire logic flush_q,
    input wire logic pc_load_q,
    input wire logic [PC_W-1:0] pc_target_q,
    input wire logic ret_push_q,
    input wire logic [PC_W-1:0] ret_addr_q,
    input wire logic ret_pop_q,
    input wire logic nop_sub_q,
    input wire logic cond_met_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // request sequences
    sequence s_go_nd;
        instr_go && instr_kind < 3'h3;
    endsequence
    sequence s_taken;
        s_go_nd ##1 stall_dec_q ##1 flush_q;
    endsequence
    sequence s_untaken;
        s_go_nd ##1 stall_dec_q ##1 !flush_q;
    endsequence

    // ==========================================================
    // assertions
    a_go_halts: assert property (s_go_nd |=> stall_dec_q)
        else $error("decode not held after conditional instruction");
    a_taken_len: assert property (s_taken |=> stall_dec_q ##1 !stall_dec_q)
        else $error("taken flow change not four cycles");
    a_untaken_len: assert property (s_untaken |-> !stall_dec_q && !pc_load_q)
        else $error("untaken flow change not two cycles");
    a_target_load: assert property (s_go_nd ##2 pc_load_q |->
        pc_target_q == $past(instr_target, 2))
        else $error("loaded target differs from second word");
    a_call_push: assert property ((instr_go && instr_kind == `CFC_K_CALL) ##2 flush_q
        |-> ret_push_q && ret_addr_q == $past(instr_next_pc, 2))
        else $error("taken call did not push its return address");
    a_exit_pop: assert property (flush_q |-> (pc_load_q != ret_pop_q))
        else $error("flush without exactly one of load or pop");
    a_flush_pulse: assert property (flush_q |=> !flush_q)
        else $error("flush longer than one cycle");
    a_delay_noflush: assert property ((instr_go && instr_kind > 3'h2 &&
        instr_kind < 3'h6) |=> (!flush_q && !stall_dec_q)[*3])
        else $error("delayed form flushed or stalled");
    a_nop_quiet: assert property (nop_sub_q |-> !pc_load_q && !flush_q)
        else $error("flow change while substituting no-operation");
endmodule // cfc_checker

/* tb/tb.sv */
// self-checking bench for cfc_flow_ctrl: table of condition rows, then odd cases
// assumes the design headers are on the include path
`timescale 1ns/100ps
`include "cfc_consts.vh"

module tb;
    typedef struct packed {logic [2:0] k; logic [10:0] c; logic [31:0] s; logic [3:0] f;
        logic m;} cfc_row_t;
    logic ref_clk, rst, instr_go, slot_go, slot_two_word, carry_flag, wrap_flag, test_flag;
    logic branch_pin, reg_wr, reg_rd;
    logic [2:0] instr_kind;
    logic [10:0] instr_cond;
    logic [15:0] instr_target, instr_next_pc;
    logic [31:0] sum_value, reg_wdata;
    logic [3:0] reg_addr;
    wire stall_dec_q, flush_q, pc_load_q, ret_push_q, ret_pop_q, nop_sub_q, cond_met_q;
    wire [15:0] pc_target_q, ret_addr_q;
    wire [31:0] reg_rdata_q;
    integer failures, n_checks, i;
    cfc_row_t rows [18];

    cfc_flow_ctrl #(.SUM_W(32), .PC_W(16), .CNT_W(16)) uut (.ref_clk(ref_clk), .rst(rst),
        .instr_go(instr_go), .instr_kind(instr_kind), .instr_cond(instr_cond),
        .instr_target(instr_target), .instr_next_pc(instr_next_pc), .slot_go(slot_go),
        .slot_two_word(slot_two_word), .sum_value(sum_value), .carry_flag(carry_flag),
        .wrap_flag(wrap_flag), .test_flag(test_flag), .branch_pin(branch_pin),
        .stall_dec_q(stall_dec_q), .flush_q(flush_q), .pc_load_q(pc_load_q),
        .pc_target_q(pc_target_q), .ret_push_q(ret_push_q), .ret_addr_q(ret_addr_q),
        .ret_pop_q(ret_pop_q), .nop_sub_q(nop_sub_q), .cond_met_q(cond_met_q),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q));

    // ==========================================================
    // clock and watchdog
    initial
    begin
        ref_clk = 1'h0;
        forever #(`CFC_CLK_NS / 2) ref_clk = ~ref_clk;
    end

    // a hang counts as a mismatch
    initial
    begin
        #(`CFC_CLK_NS * 8000);
        failures++;
        conclude;
    end

    // ==========================================================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1;
        check(reg_rdata_q, exp);
    endtask

    // pin goes through a two-stage synchroniser, so let it settle
    task automatic set_flags(input logic [31:0] s, input logic [3:0] f);
        @(posedge ref_clk);
        sum_value <= s;
        {carry_flag, wrap_flag, test_flag, branch_pin} <= f;
        repeat (3) @(posedge ref_clk);
    endtask

    // one conditional instruction with its slot words; chg alters sum beside the request
    task automatic do_op(input logic [2:0] k, input logic [10:0] cnd, input logic m,
        input logic tw, input logic chg);
        logic dl;
        begin
            dl = (k > 3'h2) && (k < 3'h6);
            @(posedge ref_clk);
            instr_go <= 1'h1;
            instr_kind <= k;
            instr_cond <= cnd;
            instr_target <= 16'hA5C0 + k;
            instr_next_pc <= 16'h1230 + k;
            if (chg)
                sum_value <= 32'h5;
            @(posedge ref_clk);
            instr_go <= 1'h0;
            #1;
            if (k < 3'h3)
            begin
                check(stall_dec_q, 1'h1);
                @(posedge ref_clk);
                #1;
                check(flush_q, m);
                check(pc_load_q, m && k != 3'h2);
                check(ret_push_q, m && k == 3'h1);
                check(ret_pop_q, m && k == 3'h2);
                check(pc_target_q, 16'hA5C0 + k);
                check(ret_addr_q, 16'h1230 + k);
                check(stall_dec_q, m);
                @(posedge ref_clk);
                #1;
                check(stall_dec_q, m);
                @(posedge ref_clk);
                #1;
                check(stall_dec_q, 1'h0);
            end
            else
            begin
                check(dl ? cond_met_q : nop_sub_q, dl ? m : !m);
                @(posedge ref_clk);
                slot_go <= 1'h1;
                slot_two_word <= tw;
                // status moves under the slots; the decision must not
                {carry_flag, wrap_flag, test_flag} <= ~{carry_flag, wrap_flag, test_flag};
                sum_value <= ~sum_value;
                if (!tw && k != 3'h6)
                begin
                    @(posedge ref_clk);
                    #1;
                    check(dl ? pc_load_q : nop_sub_q, dl ? 1'h0 : !m);
                end
                @(posedge ref_clk);
                slot_go <= 1'h0;
                #1;
                check(pc_load_q, m && (k == 3'h3 || k == 3'h4));
                check(ret_push_q, m && k == 3'h4);
                check(ret_pop_q, m && k == 3'h5);
                check(nop_sub_q, 1'h0);
            end
        end
    endtask

    task automatic conclude;
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        {rst, instr_go, slot_go, slot_two_word, reg_wr, reg_rd} = 6'h20;
        {carry_flag, wrap_flag, test_flag, branch_pin} = 4'h1;
        {instr_kind, instr_cond, instr_target, instr_next_pc} = 46'h0;
        {sum_value, reg_wdata, reg_addr} = 68'h0;
        failures = 0;
        n_checks = 0;
        // kind, condition, sum, {carry, wrap, test, pin}, met
        rows = '{'{3'h0, 11'h400, 32'h0, 4'h1, 1'h1}, '{3'h1, 11'h480, 32'h0, 4'h1, 1'h0},
            '{3'h2, 11'h500, 32'hFFFFFFFB, 4'h1, 1'h1}, '{3'h3, 11'h580, 32'h0, 4'h1, 1'h1},
            '{3'h4, 11'h600, 32'h0, 4'h1, 1'h0}, '{3'h5, 11'h680, 32'hFFFFFFFF, 4'h1, 1'h0},
            '{3'h6, 11'h040, 32'h5, 4'h1, 1'h1}, '{3'h7, 11'h060, 32'h5, 4'h1, 1'h0},
            '{3'h0, 11'h010, 32'h5, 4'h9, 1'h0}, '{3'h1, 11'h018, 32'h5, 4'h9, 1'h1},
            '{3'h3, 11'h004, 32'h5, 4'h3, 1'h0}, '{3'h4, 11'h005, 32'h5, 4'h3, 1'h1},
            '{3'h2, 11'h006, 32'h5, 4'h0, 1'h1}, '{3'h0, 11'h000, 32'h0, 4'h1, 1'h1},
            '{3'h5, 11'h545, 32'hFFFFFFF0, 4'h3, 1'h1}, '{3'h6, 11'h545, 32'hFFFFFFF0, 4'h7, 1'h0},
            '{3'h2, 11'h600, 32'h1, 4'h1, 1'h1}, '{3'h0, 11'h580, 32'h80000000, 4'h1, 1'h1}};
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        #1;
        check({stall_dec_q, flush_q, pc_load_q, ret_push_q, ret_pop_q, nop_sub_q}, 6'h0);
        reg_read(`CFC_A_CTRL, 32'h1);
        reg_read(`CFC_A_TAKEN, 32'h0);
        reg_read(4'h2, 32'h0);
        for (i = 0; i < 18; i++)
        begin
            set_flags(rows[i].s, rows[i].f);
            do_op(rows[i].k, rows[i].c, rows[i].m, 1'h0, 1'h0);
        end
        // sum changed beside the request is not seen yet
        set_flags(32'h0, 4'h1);
        do_op(3'h6, 11'h400, 1'h1, 1'h0, 1'h1);
        // a two-word first slot ends the delay slots
        do_op(3'h3, 11'h000, 1'h1, 1'h1, 1'h0);
        set_flags(32'h7, 4'h1);
        do_op(3'h7, 11'h400, 1'h0, 1'h1, 1'h0);
        reg_read(`CFC_A_TAKEN, 32'hD);
        reg_read(`CFC_A_SKIP, 32'h8);
        reg_write(`CFC_A_CTRL, 32'h2);
        reg_read(`CFC_A_TAKEN, 32'h0);
        do_op(3'h0, 11'h000, 1'h1, 1'h0, 1'h0);
        reg_read(`CFC_A_TAKEN, 32'h0);
        reg_read(`CFC_A_CTRL, 32'h0);
        conclude;
    end
endmodule // tb

bind cfc_flow_ctrl cfc_checker #(.SUM_W(SUM_W), .PC_W(PC_W), .CNT_W(CNT_W)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .instr_go(instr_go), .instr_kind(instr_kind),
    .instr_cond(instr_cond), .instr_target(instr_target), .instr_next_pc(instr_next_pc),
    .slot_go(slot_go), .slot_two_word(slot_two_word), .stall_dec_q(stall_dec_q),
    .flush_q(flush_q), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q),
    .ret_push_q(ret_push_q), .ret_addr_q(ret_addr_q), .ret_pop_q(ret_pop_q),
    .nop_sub_q(nop_sub_q), .cond_met_q(cond_met_q));
